// File: hdl/mai_beat_if.sv
// Beat timing carried from the lane clock divider to the sequencer
`timescale 1ns/100ps
interface mai_beat_if;
  logic beat_en;
  logic rise_next;
  logic clk_rise;
  logic lane_clk;
  modport src (output beat_en, output rise_next, output clk_rise, output lane_clk);
  modport snk (input beat_en, input rise_next, input clk_rise, input lane_clk);
endinterface

// File: hdl/mai_consts.svh
// Constants for the mirror array input port host controller
`ifndef MAI_CONSTS_SVH
`define MAI_CONSTS_SVH

// Timing
`define MAI_CLK_NS        4
`define MAI_RST_HOLD_NS   1000
`define MAI_RST_HOLD_CYC  ((`MAI_RST_HOLD_NS + `MAI_CLK_NS - 1) / `MAI_CLK_NS)
`define MAI_GAP_CLKS      64
`define MAI_BEAT_CYC      4
`define MAI_ROW_BEATS     8
`define MAI_LAST_ROW      11'h63f
`define MAI_TRAIN_PAT     4'h4

// Register offsets
`define MAI_REG_CTRL      8'h00
`define MAI_REG_ROWCMD    8'h04
`define MAI_REG_STATUS    8'h08
`define MAI_REG_DATA      2'h1

// Field positions
`define MAI_CTRL_RESET    0
`define MAI_CTRL_FLIP     1
`define MAI_CTRL_TWOBLK_N 2
`define MAI_CMD_MODE_LSB  0
`define MAI_CMD_ADDR_LSB  4
`define MAI_CMD_BMODE_LSB 16
`define MAI_CMD_BADDR_LSB 20
`define MAI_ST_DEV_RESET  0
`define MAI_ST_INIT       1
`define MAI_ST_READY      2
`define MAI_ST_BUSY       3
`define MAI_ST_ERR        4
`define MAI_ST_PTR_OK     5
`define MAI_ST_PTR_LSB    16

// Reset values
`define MAI_FLIP_RST      1'b0
`define MAI_TWOBLK_N_RST  1'b1

`endif

// File: hdl/mai_ctrl.sv
// Host controller driving the mirror array input port, AHB-Lite programmed
`timescale 1ns/100ps
`include "mai_consts.svh"
module mai_ctrl
  import mai_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Device reset and status
  output logic             controller_reset_n,
  input  wire logic        dev_init_active,
  // Lane clocks and data
  output logic [3:0]       lane_ddr_clock,
  output logic [15:0]      lane_a_pixel_in,
  output logic [15:0]      lane_b_pixel_in,
  output logic [15:0]      lane_c_pixel_in,
  output logic [15:0]      lane_d_pixel_in,
  output logic [3:0]       lane_frame_valid,
  // Row and block controls
  output logic [1:0]       row_write_mode,
  output logic [10:0]      row_write_addr,
  output logic             vertical_flip,
  output logic             pulse_two_blocks_n,
  output logic [1:0]       block_op_mode,
  output logic [3:0]       block_op_addr
);

  localparam logic [8:0] HOLD_LAST = 9'(`MAI_RST_HOLD_CYC - 1);
  localparam logic [8:0] GAP_LAST  = 9'(`MAI_GAP_CLKS - 1);
  localparam logic [3:0] BEATS     = 4'(`MAI_ROW_BEATS);
  localparam logic [3:0] TRAIN_PAT = `MAI_TRAIN_PAT;

  ////////////////////////////////////////////////////////////////////////////
  // Beat timing and init status

  mai_beat_if bt ();

  mai_lane_clk u_clk (
    .hclk    (hclk),
    .hresetn (hresetn),
    .bt      (bt.src)
  );

  logic init_s;

  mai_sync3 u_init (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (dev_init_active),
    .dout    (init_s)
  );

  // Divided clock goes out on every lane, always running
  assign lane_ddr_clock = {4{bt.lane_clk}};

  ////////////////////////////////////////////////////////////////////////////
  // State

  mai_state_t  state_q, state_d;
  logic [8:0]  cnt_q, cnt_d;
  logic [1:0]  pat_q, pat_d;
  logic [3:0]  beat_q, beat_d;
  logic        pend_q, pend_d;
  mai_rowcmd_t cmd_q, cmd_d;
  logic [10:0] ptr_q, ptr_d;
  logic        ptr_ok_q, ptr_ok_d;
  logic        err_q, err_d;
  logic        flip_q, flip_d;
  logic        twoblk_q, twoblk_d;
  logic        rstn_q, rstn_d;
  logic [63:0] pix_q, pix_d;
  logic        valid_q, valid_d;
  mai_rowcmd_t pin_q, pin_d;
  logic        flip_pin_q, flip_pin_d;
  logic        twoblk_pin_q, twoblk_pin_d;
  // Bus
  logic        wr_q, wr_d;
  logic [7:0]  addr_q, addr_d;
  logic [31:0] rdata_q, rdata_d;

  logic [63:0] row_mem [0:`MAI_ROW_BEATS-1];
  logic        mem_we;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic        acc;
    logic        cmd_try;
    logic        kick;
    logic        err_set;
    logic        err_clr;
    logic        at_end;
    logic        pat_bit;
    logic [63:0] rd_beat;
    mai_rowcmd_t nc;
    acc      = 1'b0;
    cmd_try  = 1'b0;
    kick     = 1'b0;
    err_set  = 1'b0;
    err_clr  = 1'b0;
    at_end   = 1'b0;
    pat_bit  = 1'b0;
    rd_beat  = 64'h0;
    nc       = mai_rowcmd_t'(19'h0);
    state_d  = state_q;
    cnt_d    = cnt_q;
    pat_d    = pat_q;
    beat_d   = beat_q;
    pend_d   = pend_q;
    cmd_d    = cmd_q;
    ptr_d    = ptr_q;
    ptr_ok_d = ptr_ok_q;
    flip_d   = flip_q;
    twoblk_d = twoblk_q;
    pix_d    = pix_q;
    valid_d  = valid_q;
    pin_d    = pin_q;
    wr_d     = 1'b0;
    addr_d   = addr_q;
    rdata_d  = rdata_q;

    // Address phase
    acc = hsel & hready & htrans[1];
    if (acc) begin
      wr_d   = hwrite;
      addr_d = haddr[7:0];
      if (!hwrite) begin
        rd_beat = row_mem[haddr[5:3]];
        if (haddr[7:6] == `MAI_REG_DATA) begin
          rdata_d = haddr[2] ? rd_beat[63:32] : rd_beat[31:0];
        end else begin
          unique case (haddr[7:0])
            `MAI_REG_CTRL: begin
              rdata_d = {29'h0, twoblk_q, flip_q, 1'b0};
            end
            `MAI_REG_ROWCMD: begin
              rdata_d = {8'h0, cmd_q.baddr, 2'h0, cmd_q.bmode,
                         1'b0, cmd_q.addr, 2'h0, cmd_q.mode};
            end
            `MAI_REG_STATUS: begin
              rdata_d = {5'h0, ptr_q, 10'h0, ptr_ok_q, err_q,
                         pend_q | (state_q == ST_SEND),
                         (state_q == ST_IDLE) | (state_q == ST_SEND),
                         init_s, ~rstn_q};
            end
            default: begin
              rdata_d = 32'h0;
            end
          endcase
        end
      end
    end

    // Data phase of a write
    if (wr_q) begin
      unique case (addr_q)
        `MAI_REG_CTRL: begin
          // Flags meant to be set once and left alone
          flip_d   = hwdata[`MAI_CTRL_FLIP];
          twoblk_d = hwdata[`MAI_CTRL_TWOBLK_N];
          kick     = hwdata[`MAI_CTRL_RESET];
        end
        `MAI_REG_ROWCMD: begin
          cmd_try = 1'b1;
        end
        `MAI_REG_STATUS: begin
          err_clr = hwdata[`MAI_ST_ERR];
        end
        default: begin
        end
      endcase
    end

    // Row command: checked against the modelled pointer
    if (cmd_try) begin
      nc.mode  = hwdata[`MAI_CMD_MODE_LSB +: 2];
      nc.addr  = hwdata[`MAI_CMD_ADDR_LSB +: 11];
      nc.bmode = hwdata[`MAI_CMD_BMODE_LSB +: 2];
      nc.baddr = hwdata[`MAI_CMD_BADDR_LSB +: 4];
      at_end   = flip_q ? (ptr_q == 11'h0) : (ptr_q == `MAI_LAST_ROW);
      // Stepping past the end or from an unknown pointer is refused
      if (pend_q || !((state_q == ST_IDLE) || (state_q == ST_SEND)) ||
          ((nc.mode == 2'b01) && (at_end || !ptr_ok_q))) begin
        err_set = 1'b1;
      end else begin
        pend_d = 1'b1;
        cmd_d  = nc;
        unique case (nc.mode)
          2'b01: begin
            ptr_d = flip_q ? ptr_q - 11'h1 : ptr_q + 11'h1;
          end
          2'b10: begin
            ptr_d    = nc.addr;
            ptr_ok_d = 1'b1;
          end
          2'b11: begin
            ptr_d    = flip_q ? `MAI_LAST_ROW : 11'h0;
            ptr_ok_d = 1'b1;
          end
          2'b00: begin
          end
        endcase
      end
    end

    // Set wins over a clear in the same cycle
    err_d = (err_q & ~err_clr) | err_set;

    pat_bit = TRAIN_PAT[2'h3 - pat_q];

    unique case (state_q)
      ST_RESET: begin
        // Clock and pattern already running while reset is held
        cnt_d = cnt_q + 9'h1;
        if (cnt_q == HOLD_LAST) begin
          cnt_d   = 9'h0;
          state_d = ST_TRAIN;
        end
      end
      ST_TRAIN: begin
        if (!init_s) begin
          state_d = ST_GAP;
          cnt_d   = 9'h0;
        end
      end
      ST_GAP: begin
        // Hold valid low for the settling clocks
        if (bt.clk_rise) begin
          cnt_d = cnt_q + 9'h1;
          if (cnt_q == GAP_LAST) begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        // Start only on a rising-edge beat, all pins together
        if (pend_q && bt.beat_en && bt.rise_next) begin
          pend_d  = 1'b0;
          valid_d = 1'b1;
          pix_d   = row_mem[0];
          pin_d   = cmd_q;
          beat_d  = 4'h1;
          state_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (bt.beat_en) begin
          if (beat_q == BEATS) begin
            // Controls drop with valid; pixels and the row and block modes and addresses are zero between rows
            valid_d = 1'b0;
            pix_d   = 64'h0;
            pin_d   = mai_rowcmd_t'(19'h0);
            state_d = ST_IDLE;
          end else begin
            pix_d  = row_mem[beat_q[2:0]];
            beat_d = beat_q + 4'h1;
          end
        end
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase

    // Training pattern on all 64 data bits and each valid
    if ((state_q == ST_RESET) || (state_q == ST_TRAIN)) begin
      pin_d = mai_rowcmd_t'(19'h0);
      if (state_d == ST_GAP) begin
        pix_d   = 64'h0;
        valid_d = 1'b0;
      end else if (bt.beat_en) begin
        pat_d   = pat_q + 2'h1;
        pix_d   = {64{pat_bit}};
        valid_d = pat_bit;
      end
    end

    // Software re-reset of the device restarts training
    if (kick) begin
      state_d  = ST_RESET;
      cnt_d    = 9'h0;
      pend_d   = 1'b0;
      ptr_ok_d = 1'b0;
    end

    rstn_d = (state_d != ST_RESET);
    // Flags held low through initialisation
    flip_pin_d   = (state_d == ST_IDLE) | (state_d == ST_SEND) ? flip_q : 1'b0;
    twoblk_pin_d = (state_d == ST_IDLE) | (state_d == ST_SEND) ? twoblk_q : 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q      <= ST_RESET;
      cnt_q        <= 9'h0;
      pat_q        <= 2'h0;
      beat_q       <= 4'h0;
      pend_q       <= 1'b0;
      cmd_q        <= mai_rowcmd_t'(19'h0);
      ptr_q        <= 11'h0;
      ptr_ok_q     <= 1'b0;
      err_q        <= 1'b0;
      flip_q       <= `MAI_FLIP_RST;
      twoblk_q     <= `MAI_TWOBLK_N_RST;
      rstn_q       <= 1'b0;
      pix_q        <= 64'h0;
      valid_q      <= 1'b0;
      pin_q        <= mai_rowcmd_t'(19'h0);
      flip_pin_q   <= 1'b0;
      twoblk_pin_q <= 1'b0;
      wr_q         <= 1'b0;
      addr_q       <= 8'h0;
      rdata_q      <= 32'h0;
    end else begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      pat_q        <= pat_d;
      beat_q       <= beat_d;
      pend_q       <= pend_d;
      cmd_q        <= cmd_d;
      ptr_q        <= ptr_d;
      ptr_ok_q     <= ptr_ok_d;
      err_q        <= err_d;
      flip_q       <= flip_d;
      twoblk_q     <= twoblk_d;
      rstn_q       <= rstn_d;
      pix_q        <= pix_d;
      valid_q      <= valid_d;
      pin_q        <= pin_d;
      flip_pin_q   <= flip_pin_d;
      twoblk_pin_q <= twoblk_pin_d;
      wr_q         <= wr_d;
      addr_q       <= addr_d;
      rdata_q      <= rdata_d;
    end
  end

  // Row beat store; writing it mid-row changes the row being sent
  assign mem_we = wr_q & (addr_q[7:6] == `MAI_REG_DATA);

  always_ff @(posedge hclk) begin
    if (mem_we) begin
      if (addr_q[2]) begin
        row_mem[addr_q[5:3]][63:32] <= hwdata;
      end else begin
        row_mem[addr_q[5:3]][31:0] <= hwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;
  assign hrdata             = rdata_q;
  assign controller_reset_n = rstn_q;
  assign lane_a_pixel_in    = pix_q[15:0];
  assign lane_b_pixel_in    = pix_q[31:16];
  assign lane_c_pixel_in    = pix_q[47:32];
  assign lane_d_pixel_in    = pix_q[63:48];
  assign lane_frame_valid   = {4{valid_q}};
  assign row_write_mode     = pin_q.mode;
  assign row_write_addr     = pin_q.addr;
  assign block_op_mode      = pin_q.bmode;
  assign block_op_addr      = pin_q.baddr;
  assign vertical_flip      = flip_pin_q;
  assign pulse_two_blocks_n = twoblk_pin_q;

endmodule

// File: hdl/mai_lane_clk.sv
// Lane clock divider: free-running DDR clock with centred data beats
`timescale 1ns/100ps
`include "mai_consts.svh"
module mai_lane_clk (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Beat timing out
  mai_beat_if.src   bt
);
  localparam logic [1:0] LAST = 2'(`MAI_BEAT_CYC - 1);
  localparam logic [1:0] HALF = 2'(`MAI_BEAT_CYC / 2);

  logic [1:0] cnt_q, cnt_d;
  logic       clk_q, clk_d;

  // Never gated: toggles from reset onward
  always_comb begin
    cnt_d = (cnt_q == LAST) ? 2'h0 : cnt_q + 2'h1;
    clk_d = (cnt_q == HALF) ? ~clk_q : clk_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 2'h0;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
    end
  end

  // Data changes at count 0, clock edge lands mid-beat
  assign bt.beat_en   = (cnt_q == 2'h0);
  assign bt.rise_next = ~clk_q;
  assign bt.clk_rise  = (cnt_q == HALF) & ~clk_q;
  assign bt.lane_clk  = clk_q;
endmodule

// File: hdl/mai_pkg.sv
// Types for the mirror array input port host controller
package mai_pkg;

  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_TRAIN = 3'b001,
    ST_GAP   = 3'b010,
    ST_IDLE  = 3'b011,
    ST_SEND  = 3'b100
  } mai_state_t;

  typedef struct packed {
    logic [3:0]  baddr;
    logic [1:0]  bmode;
    logic [10:0] addr;
    logic [1:0]  mode;
  } mai_rowcmd_t;

endpackage

// File: hdl/mai_sync3.sv
// Three-stage synchroniser; output moves once stages two and three agree
`timescale 1ns/100ps
module mai_sync3 (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Asynchronous level in, clean level out
  input  wire logic din,
  output logic      dout
);
  logic s1_q, s2_q, s3_q, out_q, out_d;

  always_comb begin
    out_d = (s2_q == s3_q) ? s3_q : out_q;
  end

  // Reset to one: assume the device is still initialising until seen otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q  <= 1'b1;
      s2_q  <= 1'b1;
      s3_q  <= 1'b1;
      out_q <= 1'b1;
    end else begin
      s1_q  <= din;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule

// File: tb/mai_ctrl_properties.sv
// Concurrent checks on the controller's lane, row and reset ports
`timescale 1ns/100ps
module mai_ctrl_properties (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Device side
  input wire logic        controller_reset_n,
  input wire logic        dev_init_active,
  input wire logic [3:0]  lane_ddr_clock,
  input wire logic [15:0] lane_a_pixel_in,
  input wire logic [15:0] lane_b_pixel_in,
  input wire logic [15:0] lane_c_pixel_in,
  input wire logic [15:0] lane_d_pixel_in,
  input wire logic [3:0]  lane_frame_valid,
  input wire logic [1:0]  row_write_mode,
  input wire logic [10:0] row_write_addr,
  input wire logic        vertical_flip,
  input wire logic        pulse_two_blocks_n,
  input wire logic [1:0]  block_op_mode,
  input wire logic [3:0]  block_op_addr
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [5:0] vcnt_q, quiet_q;
  logic [6:0] lrise_q;
  logic [8:0] rcnt_q;
  logic       row_ok;

  // Training valid pulses are excluded until init has been low a while
  assign row_ok = quiet_q == 6'h3f;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vcnt_q  <= 6'h00;
      quiet_q <= 6'h00;
      lrise_q <= 7'h00;
      rcnt_q  <= 9'h000;
    end else begin
      vcnt_q  <= lane_frame_valid[0] ? vcnt_q + 6'h01 : 6'h00;
      quiet_q <= dev_init_active ? 6'h00 : (row_ok ? quiet_q : quiet_q + 6'h01);
      lrise_q <= dev_init_active ? 7'h00 :
                 (($rose(lane_ddr_clock[0]) && lrise_q != 7'h7f) ? lrise_q + 7'h01 : lrise_q);
      rcnt_q  <= controller_reset_n ? 9'h000 : rcnt_q + 9'h001;
    end
  end

  a_clk_lanes_same: assert property (lane_ddr_clock == 4'h0 || lane_ddr_clock == 4'hf)
    else $error("lane clocks differ");
  a_vld_lanes_same: assert property (lane_frame_valid == 4'h0 || lane_frame_valid == 4'hf)
    else $error("lane valids differ");
  a_clk_free_run: assert property ($changed(lane_ddr_clock[0]) |=>
    $stable(lane_ddr_clock[0])[*3] ##1 $changed(lane_ddr_clock[0])) else $error("lane clock stalled");
  a_ctrl_idle_zero: assert property (!lane_frame_valid[0] |->
    {row_write_mode, row_write_addr, block_op_mode, block_op_addr} == 19'h0) else $error("controls live");
  a_ctrl_hold_frame: assert property (lane_frame_valid[0] && $past(lane_frame_valid[0]) |->
    $stable({row_write_mode, row_write_addr, block_op_mode, block_op_addr})) else $error("controls moved");
  a_valid_rise_align: assert property ($rose(lane_frame_valid[0]) && row_ok |->
    ##2 $rose(lane_ddr_clock[0])) else $error("valid off the rising beat");
  a_frame_len_row: assert property ($fell(lane_frame_valid[0]) && row_ok |-> vcnt_q == 6'h20)
    else $error("row frame length wrong");
  a_train_all_pins: assert property (!controller_reset_n |-> {lane_d_pixel_in, lane_c_pixel_in,
    lane_b_pixel_in, lane_a_pixel_in} == {64{lane_frame_valid[0]}}) else $error("pattern differs");
  a_flags_low_init: assert property (dev_init_active && $past(dev_init_active, 4) |->
    !vertical_flip && !pulse_two_blocks_n) else $error("flags high in init");
  a_reset_hold_len: assert property ($rose(controller_reset_n) |-> rcnt_q >= 9'h0f9)
    else $error("device reset too short");
  a_init_gap_wait: assert property ($rose(lane_frame_valid[0]) && row_ok |-> lrise_q >= 7'h40)
    else $error("valid too soon after init");

  c_row_incr: cover property ($rose(lane_frame_valid[0]) && row_write_mode == 2'b01);
  c_row_flip: cover property ($rose(lane_frame_valid[0]) && vertical_flip);
  c_dev_release: cover property ($rose(controller_reset_n));
endmodule

bind mai_ctrl mai_ctrl_properties u_props (
  .hclk(hclk), .hresetn(hresetn), .controller_reset_n(controller_reset_n),
  .dev_init_active(dev_init_active), .lane_ddr_clock(lane_ddr_clock),
  .lane_a_pixel_in(lane_a_pixel_in), .lane_b_pixel_in(lane_b_pixel_in),
  .lane_c_pixel_in(lane_c_pixel_in), .lane_d_pixel_in(lane_d_pixel_in),
  .lane_frame_valid(lane_frame_valid), .row_write_mode(row_write_mode),
  .row_write_addr(row_write_addr), .vertical_flip(vertical_flip),
  .pulse_two_blocks_n(pulse_two_blocks_n), .block_op_mode(block_op_mode),
  .block_op_addr(block_op_addr)
);

// File: tb/mai_ctrl_tb_top.sv
// Self-checking bench for the mirror array input port host controller
`timescale 1ns/100ps
module mai_ctrl_tb_top;
  localparam int TRAIN_HITS = 4;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b000;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        hreadyout, hresp, controller_reset_n, dev_init_active;
  logic        vertical_flip, pulse_two_blocks_n;
  logic [3:0]  lane_ddr_clock, lane_frame_valid, block_op_addr;
  logic [15:0] lane_a_pixel_in, lane_b_pixel_in, lane_c_pixel_in, lane_d_pixel_in;
  logic [1:0]  row_write_mode, block_op_mode;
  logic [10:0] row_write_addr;
  int          err_count = 0, check_count = 0;

  always #2 hclk = ~hclk;

  mai_ctrl u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .controller_reset_n(controller_reset_n), .dev_init_active(dev_init_active),
    .lane_ddr_clock(lane_ddr_clock), .lane_a_pixel_in(lane_a_pixel_in),
    .lane_b_pixel_in(lane_b_pixel_in), .lane_c_pixel_in(lane_c_pixel_in),
    .lane_d_pixel_in(lane_d_pixel_in), .lane_frame_valid(lane_frame_valid),
    .row_write_mode(row_write_mode), .row_write_addr(row_write_addr),
    .vertical_flip(vertical_flip), .pulse_two_blocks_n(pulse_two_blocks_n),
    .block_op_mode(block_op_mode), .block_op_addr(block_op_addr));

  mai_dev_model #(.TRAIN_HITS(TRAIN_HITS)) u_dev (
    .controller_reset_n(controller_reset_n), .dev_init_active(dev_init_active),
    .lane_ddr_clock(lane_ddr_clock), .lane_frame_valid(lane_frame_valid),
    .pixel({lane_d_pixel_in, lane_c_pixel_in, lane_b_pixel_in, lane_a_pixel_in}),
    .row_write_mode(row_write_mode), .row_write_addr(row_write_addr),
    .vertical_flip(vertical_flip), .block_op_mode(block_op_mode),
    .block_op_addr(block_op_addr));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic edge_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
  endtask

  // Single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'b010;
    htrans <= 2'b10;
    edge_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    edge_rdy();
    rd = hrdata;
  endtask

  task automatic wait_st(input logic [31:0] mask, input logic [31:0] want);
    int n;
    n = 0;
    do begin
      bus(1'b0, 32'h08, 32'h0);
      n++;
    end while ((rd & mask) !== want && n < 2000);
    if ((rd & mask) !== want) begin
      err_count++;
      report_and_stop();
    end
  endtask

  function automatic logic [31:0] mk(input logic [1:0] m, input logic [10:0] a,
                                     input logic [1:0] bm, input logic [3:0] ba);
    return {8'h00, ba, 2'b00, bm, 1'b0, a, 2'b00, m};
  endfunction

  task automatic row(input logic [31:0] cmd, input logic [10:0] exp, input logic err);
    bus(1'b1, 32'h04, cmd);
    wait_st(32'h8, 32'h0);
    check(rd[26:16], exp);
    check(rd[4], err);
    check(u_dev.ptr, exp);
    if (err) bus(1'b1, 32'h08, 32'h10);
  endtask

  task automatic t_train();
    check(controller_reset_n, 1'b0);
    check(dev_init_active, 1'b1);
    wait_st(32'h4, 32'h4);
    check(u_dev.bad, 0);
    check(u_dev.hits, TRAIN_HITS);
  endtask

  task automatic t_regs();
    bus(1'b0, 32'h00, 32'h0);
    check(rd, 32'h0000_0004);
    check(hresp, 1'b0);
    bus(1'b0, 32'h20, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 32'h40, 32'h89ab_cdef);
    bus(1'b1, 32'h44, 32'h0123_4567);
    bus(1'b0, 32'h44, 32'h0);
    check(rd, 32'h0123_4567);
  endtask

  task automatic t_rows();
    row(mk(2'b11, 11'h000, 2'b10, 4'h5), 11'h000, 1'b0);
    check(u_dev.blk_seen, 6'h25);
    check(u_dev.first_beat[31:0], 32'h89ab_cdef);
    check(u_dev.first_beat[63:32], 32'h0123_4567);
    row(mk(2'b01, 11'h000, 2'b00, 4'h0), 11'h001, 1'b0);
    row(mk(2'b10, 11'h63f, 2'b00, 4'h0), 11'h63f, 1'b0);
    row(mk(2'b01, 11'h000, 2'b00, 4'h0), 11'h63f, 1'b1);
    row(mk(2'b00, 11'h000, 2'b01, 4'h9), 11'h63f, 1'b0);
    check(u_dev.blk_seen, 6'h19);
  endtask

  task automatic t_flip();
    bus(1'b1, 32'h00, 32'h6);
    repeat (2) @(posedge hclk);
    check(vertical_flip, 1'b1);
    check(pulse_two_blocks_n, 1'b1);
    row(mk(2'b11, 11'h000, 2'b00, 4'h0), 11'h63f, 1'b0);
    row(mk(2'b01, 11'h000, 2'b00, 4'h0), 11'h63e, 1'b0);
    row(mk(2'b10, 11'h000, 2'b00, 4'h0), 11'h000, 1'b0);
    row(mk(2'b01, 11'h000, 2'b00, 4'h0), 11'h000, 1'b1);
    check(u_dev.rows, 7);
    bus(1'b1, 32'h00, 32'h4);
  endtask

  // Re-reset through the control register, then the pointer is unknown
  task automatic t_rereset();
    bus(1'b1, 32'h00, 32'h5);
    repeat (3) @(posedge hclk);
    t_train();
    bus(1'b1, 32'h04, mk(2'b01, 11'h000, 2'b00, 4'h0));
    wait_st(32'h8, 32'h0);
    check(rd[5:4], 2'b01);
    check(u_dev.gap_err, 0);
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_train();
    t_regs();
    t_rows();
    t_flip();
    t_rereset();
    report_and_stop();
  end
endmodule

// File: tb/mai_dev_model.sv
// Device-side model: trains on the lane pattern, then frames rows
`timescale 1ns/100ps
module mai_dev_model #(
  parameter int TRAIN_HITS = 4
) (
  // Device reset and status
  input  wire logic        controller_reset_n,
  output logic             dev_init_active,
  // Lanes packed d, c, b, a
  input  wire logic [3:0]  lane_ddr_clock,
  input  wire logic [63:0] pixel,
  input  wire logic [3:0]  lane_frame_valid,
  // Row and block controls
  input  wire logic [1:0]  row_write_mode,
  input  wire logic [10:0] row_write_addr,
  input  wire logic        vertical_flip,
  input  wire logic [1:0]  block_op_mode,
  input  wire logic [3:0]  block_op_addr
);
  logic [10:0] ptr;
  logic [63:0] first_beat;
  logic [5:0]  blk_seen;
  logic [3:0]  shift;
  logic        vld_q = 1'b0;
  logic        lc_q = 1'b0;
  logic        init_q = 1'b1;
  int          hits = 0, bad = 0, gap_err = 0, rises = 0, rows = 0;

  // One driver for the status pin, set up before any edge arrives
  assign dev_init_active = init_q;

  // One process for reset and lane edges, so init status never races training
  always @(lane_ddr_clock[0] or negedge controller_reset_n) begin
    if (!controller_reset_n) begin
      init_q = 1'b1;
      hits = 0;
    end
    if (lane_ddr_clock[0] !== lc_q) begin
      lc_q = lane_ddr_clock[0];
      if (init_q) begin
        if (pixel !== {64{pixel[0]}} || lane_frame_valid !== {4{pixel[0]}}) bad++;
        shift = {shift[2:0], pixel[0]};
        // Phase search stands in as a count of aligned pattern hits
        if (controller_reset_n && shift == 4'b0100) hits++;
        if (hits == TRAIN_HITS) begin
          init_q = 1'b0;
          rises = 0;
        end
      end else begin
        if (lc_q) rises++;
        if (lane_frame_valid[0] && !vld_q) begin
          if (rises < 64) gap_err++;
          first_beat = pixel;
          blk_seen = {block_op_mode, block_op_addr};
          rows++;
          case (row_write_mode)
            2'b01: begin
              if (ptr === (vertical_flip ? 11'h000 : 11'h63f)) bad++;
              ptr = vertical_flip ? ptr - 11'h001 : ptr + 11'h001;
            end
            2'b10: ptr = row_write_addr;
            2'b11: ptr = vertical_flip ? 11'h63f : 11'h000;
            default: ;
          endcase
        end
      end
      vld_q = lane_frame_valid[0];
    end
  end
endmodule
